// ---- design/tsdsup_pkg.sv ----
package tsdsup_pkg;

  // Register byte offsets
  localparam logic [7:0] TSDSUP_CTRL_OFS = 8'h00;
  localparam logic [7:0] TSDSUP_STAT_OFS = 8'h04;
  localparam logic [7:0] TSDSUP_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] TSDSUP_IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] TSDSUP_MODE_OFS = 8'h10;

  // Control register bit positions
  localparam int TSDSUP_CTRL_EXT_EN_BIT = 0;
  localparam int TSDSUP_CTRL_THR_BIT = 1;
  localparam int TSDSUP_CTRL_SHORT_RD_BIT = 2;
  localparam int TSDSUP_CTRL_SLEEP_REQ_BIT = 3;

  // Status register bit positions (W1C for the flags)
  localparam int TSDSUP_STAT_EVT_BIT = 0;
  localparam int TSDSUP_STAT_LATCH_BIT = 1;
  localparam int TSDSUP_STAT_OV_BIT = 2;
  localparam int TSDSUP_STAT_SC_BIT = 3;
  localparam int TSDSUP_STAT_CNT_LSB = 8;

  // Interrupt status bit positions
  localparam int TSDSUP_IRQ_OT_BIT = 0;
  localparam int TSDSUP_IRQ_LATCH_BIT = 1;
  localparam int TSDSUP_IRQ_OV_BIT = 2;
  localparam int TSDSUP_IRQ_SC_BIT = 3;
  localparam int TSDSUP_IRQ_RESTART_BIT = 4;
  localparam int TSDSUP_IRQ_W = 5;

  // Reset values
  localparam logic [3:0] TSDSUP_CTRL_RST = 4'h0;
  localparam logic [TSDSUP_IRQ_W-1:0] TSDSUP_MASK_RST = 5'h00;

  // Event counting
  localparam int TSDSUP_EVT_LIMIT = 16;
  localparam int TSDSUP_EXT_FACTOR = 64;

  // Timing, clock 10 MHz
  localparam int TSDSUP_CLK_HZ = 10_000_000;
  localparam int TSDSUP_LONG_RD_MS = 10;
  localparam int TSDSUP_SHORT_RD_MS = 2;
  localparam int TSDSUP_OV_FILT_US = 64;
  localparam int TSDSUP_SC_FILT_MS = 2;
  localparam int TSDSUP_LONG_RD_CYC = TSDSUP_CLK_HZ / 1000 * TSDSUP_LONG_RD_MS;
  localparam int TSDSUP_SHORT_RD_CYC = TSDSUP_CLK_HZ / 1000 * TSDSUP_SHORT_RD_MS;
  localparam int TSDSUP_OV_FILT_CYC = TSDSUP_CLK_HZ / 1_000_000 * TSDSUP_OV_FILT_US;
  localparam int TSDSUP_SC_FILT_CYC = TSDSUP_CLK_HZ / 1000 * TSDSUP_SC_FILT_MS;
  localparam int TSDSUP_COOLDOWN_CYC = 50_000;

  // Operating modes
  typedef enum logic [2:0] {
    TSDSUP_NORMAL,
    TSDSUP_SLEEP_ENTRY,
    TSDSUP_SLEEP,
    TSDSUP_FAILSAFE,
    TSDSUP_RESTART
  } tsdsup_mode_t;

  // AXI response codes
  localparam logic [1:0] TSDSUP_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSDSUP_RESP_SLVERR = 2'h2;

endpackage : tsdsup_pkg

// ---- design/tsdsup_top.sv ----
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module tsdsup_top
  import tsdsup_pkg::*;
#(
  parameter int COOLDOWN_CYC = TSDSUP_COOLDOWN_CYC,
  parameter int LONG_RD_CYC = TSDSUP_LONG_RD_CYC,
  parameter int SHORT_RD_CYC = TSDSUP_SHORT_RD_CYC,
  parameter int SC_FILT_CYC = TSDSUP_SC_FILT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_overtemp,
  input wire logic main_supply_overvolt,
  input wire logic main_supply_low,
  output logic raised_thermal_threshold_select,
  output logic main_supply_enable,
  output logic reset_out_n,
  output logic [2:0] mode_out,
  output logic irq
);

  // Internal state
  tsdsup_mode_t mode_q;
  logic [31:0] timer_q;
  logic [4:0] evt_cnt_q;
  logic evt_flag_q;
  logic latch_q;
  logic ovt_q;
  logic [3:0] ctrl_q;
  logic ov_flag_q;
  logic sc_flag_q;
  logic [15:0] ov_cnt_q;
  logic [31:0] sc_cnt_q;
  logic [TSDSUP_IRQ_W-1:0] irq_stat_q;
  logic [TSDSUP_IRQ_W-1:0] irq_mask_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic ot_rise;
  logic evt_clr;
  logic latch_clr;
  logic ext_dis;
  logic ov_detect;
  logic sc_detect;
  logic restart_evt;
  logic [31:0] wait_cyc;
  logic cnt_full_q;
  logic cnt_reach;
  logic [7:0] ctrl_wdata;
  logic ctrl_wr;
  logic stat_wr;
  logic irqs_wr;
  logic mask_wr;

  // Byte lane 0 write data of the stored write
  function automatic logic [7:0] lane0(input logic [31:0] d, input logic [3:0] s, input logic [7:0] old);
    lane0 = s[0] ? d[7:0] : old;
  endfunction : lane0

  // Stored write hits this word with lane 0 enabled; other lanes carry nothing
  function automatic logic lane0_hit(input logic fire, input logic [7:0] addr, input logic [3:0] s,
    input logic [7:0] ofs);
    lane0_hit = fire && addr == ofs && s[0];
  endfunction : lane0_hit

  // Write channel capture: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response, one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TSDSUP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q[7:2] <= TSDSUP_IRQ_MASK_OFS[7:2] && awaddr_q[1:0] == 2'h0) begin
        s_axi_bresp <= TSDSUP_RESP_OKAY;
      end else begin
        s_axi_bresp <= TSDSUP_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Per-register write strobes from the stored request
  assign ctrl_wr = lane0_hit(wr_fire, awaddr_q, wstrb_q, TSDSUP_CTRL_OFS);
  assign stat_wr = lane0_hit(wr_fire, awaddr_q, wstrb_q, TSDSUP_STAT_OFS);
  assign irqs_wr = lane0_hit(wr_fire, awaddr_q, wstrb_q, TSDSUP_IRQ_STAT_OFS);
  assign mask_wr = lane0_hit(wr_fire, awaddr_q, wstrb_q, TSDSUP_IRQ_MASK_OFS);

  // Decoded write effects on lane 0: W1C status clears, and a control write with extension off clears the count
  assign evt_clr = stat_wr && wdata_q[TSDSUP_STAT_EVT_BIT] && mode_q == TSDSUP_NORMAL && !chip_overtemp;
  assign latch_clr = stat_wr && wdata_q[TSDSUP_STAT_LATCH_BIT];
  assign ext_dis = ctrl_wr && !wdata_q[TSDSUP_CTRL_EXT_EN_BIT];

  // Control register
  assign ctrl_wdata = lane0(wdata_q, wstrb_q, {4'h0, ctrl_q});
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= TSDSUP_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= ctrl_wdata[3:0];
      end
      if (mode_q != TSDSUP_NORMAL) begin
        ctrl_q[TSDSUP_CTRL_SLEEP_REQ_BIT] <= 1'b0; // Sleep request is one-shot
      end
    end
  end

  assign raised_thermal_threshold_select = ctrl_q[TSDSUP_CTRL_THR_BIT];

  // Overtemperature edge, one event per excursion
  // Starts low like the idle pin, so reset makes no false event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovt_q <= 1'b0;
    end else begin
      ovt_q <= chip_overtemp;
    end
  end
  assign ot_rise = chip_overtemp && !ovt_q;

  // Event flag; a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_flag_q <= 1'b0;
    end else if (ot_rise) begin
      evt_flag_q <= 1'b1;
    end else if (evt_clr) begin
      evt_flag_q <= 1'b0;
    end
  end

  // Event counter, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_cnt_q <= 5'h00;
    end else if (evt_clr || ext_dis) begin
      evt_cnt_q <= 5'h00;
    end else if (ot_rise && ctrl_q[TSDSUP_CTRL_EXT_EN_BIT] && evt_cnt_q < 5'(TSDSUP_EVT_LIMIT)) begin
      evt_cnt_q <= evt_cnt_q + 5'h01;
    end
  end

  // Arrival at 16 is a one-cycle event, not a level: a saturated count
  // would otherwise set the latch again and lock out the software clear
  assign cnt_reach = evt_cnt_q == 5'(TSDSUP_EVT_LIMIT) && !cnt_full_q;

  // Latched extension flag; arrival at 16 wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_full_q <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      cnt_full_q <= evt_cnt_q == 5'(TSDSUP_EVT_LIMIT);
      if (cnt_reach) begin
        latch_q <= 1'b1;
      end else if (latch_clr) begin
        latch_q <= 1'b0;
      end
    end
  end

  // Cool-down length; extension kept while latched
  assign wait_cyc = latch_q ? 32'(COOLDOWN_CYC * TSDSUP_EXT_FACTOR) : 32'(COOLDOWN_CYC);

  // Mode sequencer with a shared timer
  // One timer serves cool-down and reset release; the two never overlap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= TSDSUP_RESTART;
      timer_q <= 32'h0000_0000;
    end else if (chip_overtemp && mode_q != TSDSUP_FAILSAFE) begin
      mode_q <= TSDSUP_FAILSAFE;
      timer_q <= 32'h0000_0000;
    end else begin
      case (mode_q)
        TSDSUP_NORMAL: begin
          if (ctrl_q[TSDSUP_CTRL_SLEEP_REQ_BIT]) begin
            mode_q <= TSDSUP_SLEEP_ENTRY;
          end
        end
        TSDSUP_SLEEP_ENTRY: begin
          mode_q <= TSDSUP_SLEEP; // Overtemp already caught above
        end
        TSDSUP_SLEEP: begin
          mode_q <= TSDSUP_SLEEP; // Left only by reset or overtemp
        end
        TSDSUP_FAILSAFE: begin
          if (chip_overtemp) begin
            timer_q <= 32'h0000_0000;
          end else if (timer_q >= wait_cyc - 32'h0000_0001) begin
            mode_q <= TSDSUP_RESTART;
            timer_q <= 32'h0000_0000;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
          end
        end
        TSDSUP_RESTART: begin
          if (timer_q >= (ctrl_q[TSDSUP_CTRL_SHORT_RD_BIT] ? 32'(SHORT_RD_CYC) : 32'(LONG_RD_CYC))
                         - 32'h0000_0001) begin
            mode_q <= TSDSUP_NORMAL;
            timer_q <= 32'h0000_0000;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
          end
        end
        default: begin
          mode_q <= TSDSUP_FAILSAFE;
        end
      endcase
    end
  end

  // Restart entry pulse; the timer is zero only on the first restart cycle
  assign restart_evt = mode_q == TSDSUP_RESTART && timer_q == 32'h0000_0000;
  // Pin decodes; the processor stays in reset outside normal running and sleep entry
  assign reset_out_n = mode_q == TSDSUP_NORMAL || mode_q == TSDSUP_SLEEP_ENTRY;
  assign main_supply_enable = mode_q != TSDSUP_FAILSAFE && mode_q != TSDSUP_SLEEP;
  assign mode_out = mode_q;

  // Overvoltage persistence filter
  // Counter parks at the limit so one long excursion flags only once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_cnt_q <= 16'h0000;
    end else if (!main_supply_overvolt) begin
      ov_cnt_q <= 16'h0000;
    end else if (ov_cnt_q < 16'(TSDSUP_OV_FILT_CYC)) begin
      ov_cnt_q <= ov_cnt_q + 16'h0001;
    end
  end
  assign ov_detect = ov_cnt_q == 16'(TSDSUP_OV_FILT_CYC - 1) && main_supply_overvolt;

  // Short-to-ground filter; also blanks the rail during power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_cnt_q <= 32'h0000_0000;
    end else if (!main_supply_low || !main_supply_enable) begin
      sc_cnt_q <= 32'h0000_0000;
    end else if (sc_cnt_q < 32'(SC_FILT_CYC)) begin
      sc_cnt_q <= sc_cnt_q + 32'h0000_0001;
    end
  end
  assign sc_detect = sc_cnt_q == 32'(SC_FILT_CYC - 1) && main_supply_low && main_supply_enable;

  // Diagnostic flags, set wins over W1C
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_flag_q <= 1'b0;
      sc_flag_q <= 1'b0;
    end else begin
      if (ov_detect) begin
        ov_flag_q <= 1'b1;
      end else if (stat_wr && wdata_q[TSDSUP_STAT_OV_BIT]) begin
        ov_flag_q <= 1'b0;
      end
      if (sc_detect) begin
        sc_flag_q <= 1'b1;
      end else if (stat_wr && wdata_q[TSDSUP_STAT_SC_BIT]) begin
        sc_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt status and mask; events beat same-cycle clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= TSDSUP_MASK_RST;
    end else begin
      if (mask_wr) begin
        irq_mask_q <= wdata_q[TSDSUP_IRQ_W-1:0];
      end
      irq_stat_q <= (irq_stat_q & ~(irqs_wr ? wdata_q[TSDSUP_IRQ_W-1:0] : 5'h00))
                    | {restart_evt, sc_detect, ov_detect, cnt_reach, ot_rise};
    end
  end

  // Level output; stays up until the status bit is cleared or masked
  assign irq = |(irq_stat_q & irq_mask_q);

  // Read channel; unmapped reads answer SLVERR with zero data
  // Only one read in flight, so arready simply waits for rvalid to go
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TSDSUP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= TSDSUP_RESP_OKAY;
      if (s_axi_araddr == TSDSUP_CTRL_OFS) begin
        s_axi_rdata <= {28'h0000000, ctrl_q};
      end else if (s_axi_araddr == TSDSUP_STAT_OFS) begin
        s_axi_rdata <= {19'h00000, evt_cnt_q, 4'h0, sc_flag_q, ov_flag_q, latch_q, evt_flag_q};
      end else if (s_axi_araddr == TSDSUP_IRQ_STAT_OFS) begin
        s_axi_rdata <= {27'h0000000, irq_stat_q};
      end else if (s_axi_araddr == TSDSUP_IRQ_MASK_OFS) begin
        s_axi_rdata <= {27'h0000000, irq_mask_q};
      end else if (s_axi_araddr == TSDSUP_MODE_OFS) begin
        s_axi_rdata <= {29'h00000000, mode_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= TSDSUP_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : tsdsup_top

// ---- bench/tsdsup_props.sv ----
`timescale 1ns/1ns
module tsdsup_props
  import tsdsup_pkg::*;
#(
  parameter int COOLDOWN_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic chip_overtemp,
  input wire logic raised_thermal_threshold_select,
  input wire logic main_supply_enable,
  input wire logic reset_out_n,
  input wire logic [2:0] mode_out
);
  logic [31:0] cool_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cool-down cycles so far; heat restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_out != TSDSUP_FAILSAFE || chip_overtemp) begin
      cool_q <= 32'h0;
    end else begin
      cool_q <= cool_q + 32'h1;
    end
  end
  sequence s_fs_exit;
    mode_out == TSDSUP_FAILSAFE ##1 mode_out != TSDSUP_FAILSAFE;
  endsequence
  sequence s_quiet;
    !s_axi_wvalid ##1 !s_axi_wvalid;
  endsequence
  property p_ot_fs;
    $rose(chip_overtemp) |-> ##[0:2] mode_out == TSDSUP_FAILSAFE;
  endproperty
  property p_fs_hold;
    mode_out == TSDSUP_FAILSAFE && chip_overtemp |=> mode_out == TSDSUP_FAILSAFE;
  endproperty
  // Count includes the exit edge, so it equals the wait on leaving
  property p_fs_wait;
    s_fs_exit |-> cool_q >= 32'(COOLDOWN_CYC);
  endproperty
  property p_fs_exit;
    s_fs_exit |-> mode_out == TSDSUP_RESTART;
  endproperty
  property p_rst_out;
    reset_out_n == (mode_out == TSDSUP_NORMAL || mode_out == TSDSUP_SLEEP_ENTRY);
  endproperty
  property p_supply;
    main_supply_enable == !(mode_out == TSDSUP_FAILSAFE || mode_out == TSDSUP_SLEEP);
  endproperty
  property p_no_sleep;
    mode_out == TSDSUP_SLEEP_ENTRY && chip_overtemp |=> mode_out != TSDSUP_SLEEP;
  endproperty
  property p_thr;
    s_quiet |=> $stable(raised_thermal_threshold_select);
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_ot_fs: assert property (p_ot_fs) else $error("no fail-safe");
  a_fs_hold: assert property (p_fs_hold) else $error("left while hot");
  a_fs_wait: assert property (p_fs_wait) else $error("wait short");
  a_fs_exit: assert property (p_fs_exit) else $error("no restart");
  a_rst_out: assert property (p_rst_out) else $error("reset out");
  a_supply: assert property (p_supply) else $error("supply enable");
  a_no_sleep: assert property (p_no_sleep) else $error("slept hot");
  a_thr: assert property (p_thr) else $error("select moved");
  a_bhold: assert property (p_bhold) else $error("b dropped");
  a_bdone: assert property (p_bdone) else $error("b repeated");
endmodule : tsdsup_props

bind tsdsup_top tsdsup_props #(.COOLDOWN_CYC(COOLDOWN_CYC)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .chip_overtemp(chip_overtemp), .mode_out(mode_out),
  .raised_thermal_threshold_select(raised_thermal_threshold_select),
  .main_supply_enable(main_supply_enable), .reset_out_n(reset_out_n));

// ---- bench/tsdsup_mcu_model.sv ----
`timescale 1ns/1ns
module tsdsup_mcu_model #(
  parameter int RAMP_CYC = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic main_supply_enable,
  input wire logic short_req,
  output logic main_supply_low
);
  logic [7:0] ramp_q;
  // Rail ramp after each enable, kept inside the blanking time
  always_ff @(posedge aclk) begin
    if (!aresetn || !main_supply_enable) begin
      ramp_q <= 8'(RAMP_CYC);
    end else if (ramp_q != 8'h0) begin
      ramp_q <= ramp_q - 8'h1;
    end
  end
  // Low while off, ramping or shorted
  assign main_supply_low = !main_supply_enable || ramp_q != 8'h0 || short_req;
endmodule : tsdsup_mcu_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top
  import tsdsup_pkg::*;
;
  localparam int CD = 20;
  localparam int LRD = 50;
  localparam int SRD = 10;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, short_req;
  logic chip_overtemp, main_supply_overvolt, main_supply_low, raised_thermal_threshold_select;
  logic main_supply_enable, reset_out_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, dat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] mode_out;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int rd_exp, n;
  // Clock of 100 ns
  always #50 aclk = ~aclk;
  tsdsup_top #(.COOLDOWN_CYC(CD), .LONG_RD_CYC(LRD), .SHORT_RD_CYC(SRD), .SC_FILT_CYC(30)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .chip_overtemp(chip_overtemp), .main_supply_overvolt(main_supply_overvolt),
    .main_supply_low(main_supply_low), .raised_thermal_threshold_select(raised_thermal_threshold_select),
    .main_supply_enable(main_supply_enable), .reset_out_n(reset_out_n), .mode_out(mode_out), .irq(irq));
  tsdsup_mcu_model u_mcu (.aclk(aclk), .aresetn(aresetn), .main_supply_enable(main_supply_enable),
    .short_req(short_req), .main_supply_low(main_supply_low));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic int exp_wait(input bit ext);
    return ext ? CD * TSDSUP_EXT_FACTOR : CD;
  endfunction : exp_wait
  // Flag, latch and saturated count after k events
  function automatic logic [31:0] exp_stat(input int k);
    int c;
    c = (k > TSDSUP_EVT_LIMIT) ? TSDSUP_EVT_LIMIT : k;
    return (32'(c) << 8) | ((k >= TSDSUP_EVT_LIMIT) ? 32'h3 : 32'h1);
  endfunction : exp_stat
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Write: address and data released as each is taken; bready stays high all run
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask : axw
  // Read: data taken at the edge where rvalid is seen with rready high
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : axr
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, r);
    chk(r, TSDSUP_RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axr(a, dat, r);
    chk(dat, e);
  endtask : rd
  task automatic wmode(input logic [2:0] m, output int c);
    c = 0;
    while (mode_out !== m && c < 4000) begin
      @(posedge aclk);
      c++;
    end
    chk(c < 4000, 1);
  endtask : wmode
  // Event of random length; a clear is tried while still hot
  task automatic ot(input int w);
    seed = xs(seed);
    chip_overtemp <= 1'b1;
    repeat (2 + int'(seed[2:0])) @(posedge aclk);
    chk(mode_out, TSDSUP_FAILSAFE);
    chk(main_supply_enable, 0);
    chk(reset_out_n, 0);
    wr(TSDSUP_STAT_OFS, 32'h1);
    chip_overtemp <= 1'b0;
    wmode(TSDSUP_RESTART, n);
    if (w > 0) chk(n >= w - 1 && n <= w + 3, 1);
    wmode(TSDSUP_NORMAL, n);
    chk(n >= rd_exp - 1 && n <= rd_exp + 3, 1);
    chk(reset_out_n, 1);
  endtask : ot
  task automatic pulse(input bit sc, input int len, input logic [31:0] e);
    if (sc) short_req <= 1'b1;
    else main_supply_overvolt <= 1'b1;
    repeat (len) @(posedge aclk);
    {short_req, main_supply_overvolt} <= 2'b00;
    rd(TSDSUP_STAT_OFS, e);
  endtask : pulse
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      test_done();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {chip_overtemp, main_supply_overvolt, short_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'h7CFEAEED;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(mode_out, TSDSUP_RESTART);
    wmode(TSDSUP_NORMAL, n);
    chk(n >= LRD - 2 && n <= LRD + 2, 1);
    rd(TSDSUP_CTRL_OFS, 32'h0);
    rd(TSDSUP_IRQ_MASK_OFS, 32'h0);
    seed = xs(seed);
    wr(TSDSUP_IRQ_MASK_OFS, seed);
    rd(TSDSUP_IRQ_MASK_OFS, seed & 32'h1F);
    wr(TSDSUP_IRQ_MASK_OFS, 32'h1);
    wr(TSDSUP_CTRL_OFS, 32'h6);
    chk(raised_thermal_threshold_select, 1);
    rd_exp = SRD;
    ot(exp_wait(0));
    chk(irq, 1);
    rd(TSDSUP_STAT_OFS, 32'h1);
    wr(TSDSUP_IRQ_STAT_OFS, 32'h1F);
    chk(irq, 0);
    wr(TSDSUP_STAT_OFS, 32'h1);
    rd(TSDSUP_STAT_OFS, 32'h0);
    // Seventeen events with the flag left set
    wr(TSDSUP_CTRL_OFS, 32'h7);
    for (int k = 1; k <= 17; k++) begin
      ot(exp_wait(k >= 16));
      rd(TSDSUP_STAT_OFS, exp_stat(k));
    end
    // Latch cleared while the count still sits at 16
    wr(TSDSUP_STAT_OFS, 32'h2);
    rd(TSDSUP_STAT_OFS, 32'h1001);
    wr(TSDSUP_CTRL_OFS, 32'h6);
    rd(TSDSUP_STAT_OFS, 32'h1);
    ot(exp_wait(0));
    wr(TSDSUP_CTRL_OFS, 32'h7);
    ot(exp_wait(0));
    wr(TSDSUP_STAT_OFS, 32'h1);
    rd(TSDSUP_STAT_OFS, 32'h0);
    // Heat arrives on the edge that samples sleep entry
    wr(TSDSUP_CTRL_OFS, 32'hE);
    ot(exp_wait(0));
    wr(TSDSUP_STAT_OFS, 32'hF);
    pulse(0, 500, 32'h0);
    pulse(0, 810, 32'h4);
    pulse(1, 20, 32'h4);
    pulse(1, 40, 32'hC);
    axw(8'h14, 32'h1, r);
    chk(r, TSDSUP_RESP_SLVERR);
    axw(TSDSUP_MODE_OFS, 32'h1, r);
    chk(r, TSDSUP_RESP_SLVERR);
    axr(8'h14, dat, r);
    chk(dat, 32'h0);
    chk(r, TSDSUP_RESP_SLVERR);
    test_done();
  end
endmodule : tb_top
